/* shared/hbridge_pkg.sv */
// Constants, field layout and carrier types of the H-bridge control block.
// Assumes a single 125 MHz clock domain and word-wide AHB-Lite register access.
package hbridge_pkg;

    // Register byte addresses
    localparam logic [7:0] CONFIG_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] MASK_ADDR = 8'h08;
    localparam logic [7:0] STATE_ADDR = 8'h0C;

    // Configuration field positions
    localparam int CFG_WIDTH = 6;
    localparam int CFG_EN_FIRST_BIT = 0;
    localparam int CFG_EN_SECOND_BIT = 1;
    localparam int CFG_FLAG_MODE_BIT = 2;
    localparam int CFG_SERIAL_CTRL_BIT = 3;
    localparam int CFG_SERIAL_ONE_BIT = 4;
    localparam int CFG_SERIAL_TWO_BIT = 5;
    localparam logic [CFG_WIDTH-1:0] CONFIG_RESET = 6'h03;

    // Event bits, shared by status and mask
    localparam int EVT_WIDTH = 4;
    localparam int EVT_SHUTDOWN_BIT = 0;
    localparam int EVT_SUPPLY_BIT = 1;
    localparam int EVT_LIMIT_BIT = 2;
    localparam int EVT_LOGIC_SUPPLY_BIT = 3;
    localparam logic [EVT_WIDTH-1:0] STATUS_RESET = 4'h0;
    localparam logic [EVT_WIDTH-1:0] MASK_RESET = 4'h0;

    // State register field positions
    localparam int ST_MODE_LSB = 0;
    localparam int ST_LOCKOUT_BIT = 2;
    localparam int ST_FLAG_LOW_BIT = 3;
    localparam int ST_ENABLE_BIT = 4;
    localparam int ST_DISABLE_BIT = 5;
    localparam int ST_ONE_BIT = 6;
    localparam int ST_TWO_BIT = 7;

    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int LIMIT_ON_NS = 16000;
    localparam int LIMIT_ON_CYCLES = (LIMIT_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LIMIT_CNT_WIDTH = 12;

    typedef enum logic [1:0] {
        MODE_STANDBY,
        MODE_NORMAL,
        MODE_DIAG,
        MODE_FAULT
    } mode_t;

    typedef struct packed {
        logic drive_input_one;
        logic drive_input_two;
        logic enable_pin_alias;
        logic disable_or_fault_pin;
    } ctrl_pins_t;

    // Level each control pin takes when nothing drives it
    localparam ctrl_pins_t PIN_PULL = '{
        drive_input_one: 1'b1,
        drive_input_two: 1'b1,
        enable_pin_alias: 1'b0,
        disable_or_fault_pin: 1'b1
    };

    typedef struct packed {
        logic supply_under;
        logic over_temp;
        logic over_current;
        logic logic_supply_bad;
        logic limit_one;
        logic limit_two;
    } fault_in_t;

endpackage : hbridge_pkg

/* rtl/limit_pulse.sv */
// Fixed-length pulse timer for one output under peak current limitation.
// Assumes the trigger is synchronous to hclk.
`timescale 1ns/10ps
module limit_pulse
    import hbridge_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic trigger,
    output logic active
);

    logic [LIMIT_CNT_WIDTH-1:0] count_q;
    logic [LIMIT_CNT_WIDTH-1:0] count_d;

    always_comb begin
        count_d = count_q;
        if (count_q != '0) begin
            count_d = count_q - 12'h001;
        end else if (trigger) begin
            count_d = LIMIT_CNT_WIDTH'(LIMIT_ON_CYCLES);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= '0;
        end else if (ce) begin
            count_q <= count_d;
        end
    end

    assign active = (count_q != '0);

endmodule : limit_pulse

/* rtl/h_bridge_control_logic.sv */
// Bridge control logic: pin decoding, fault lockout, flag pin, AHB-Lite registers.
// Assumes pins and fault inputs are synchronous to hclk; outputs z when _oe is low.
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
module h_bridge_control_logic
    import hbridge_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire ctrl_pins_t pin_level,
    input wire ctrl_pins_t pin_driven,
    input wire fault_in_t fault_in,
    output logic disable_or_fault_pin_o,
    output logic disable_or_fault_pin_oe,
    output logic bridge_output_one_o,
    output logic bridge_output_one_oe,
    output logic bridge_output_two_o,
    output logic bridge_output_two_oe,
    output logic irq
);

    // Register and bus state
    logic [CFG_WIDTH-1:0] config_q;
    logic [CFG_WIDTH-1:0] config_d;
    logic [EVT_WIDTH-1:0] status_q;
    logic [EVT_WIDTH-1:0] status_d;
    logic [EVT_WIDTH-1:0] mask_q;
    logic [EVT_WIDTH-1:0] mask_d;
    logic [7:0] addr_q;
    logic [7:0] addr_d;
    logic wr_q;
    logic wr_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic hreadyout_q;
    logic irq_q;
    logic irq_d;

    // Bridge state
    mode_t mode_q;
    mode_t mode_d;
    logic lockout_q;
    logic lockout_d;
    logic enable_prev_q;
    logic disable_prev_q;
    logic flag_low_q;
    logic flag_low_d;
    logic one_o_q;
    logic one_o_d;
    logic one_oe_q;
    logic one_oe_d;
    logic two_o_q;
    logic two_o_d;
    logic two_oe_q;
    logic two_oe_d;

    // Combinational helpers
    ctrl_pins_t pins;
    logic flag_mode;
    logic disable_active;
    logic bridge_enabled;
    logic channels_on;
    logic shutdown;
    logic reactivate;
    logic outputs_active;
    logic level_one;
    logic level_two;
    logic pulse_one;
    logic pulse_two;
    logic [EVT_WIDTH-1:0] events;
    logic addr_phase;

    // Pin level with the internal pull applied to an open pin
    function automatic ctrl_pins_t resolve_pins(input ctrl_pins_t level,
                                                input ctrl_pins_t driven);
        resolve_pins = (level & driven) | (PIN_PULL & ~driven);
    endfunction : resolve_pins

    // Register read mux
    function automatic logic [31:0] read_word(input logic [7:0] addr,
                                              input logic [CFG_WIDTH-1:0] cfg,
                                              input logic [EVT_WIDTH-1:0] sts,
                                              input logic [EVT_WIDTH-1:0] msk,
                                              input logic [7:0] state);
        case (addr)
            CONFIG_ADDR: read_word = {{(32-CFG_WIDTH){1'b0}}, cfg};
            STATUS_ADDR: read_word = {{(32-EVT_WIDTH){1'b0}}, sts};
            MASK_ADDR: read_word = {{(32-EVT_WIDTH){1'b0}}, msk};
            STATE_ADDR: read_word = {24'h000000, state};
            default: read_word = 32'h00000000;
        endcase
    endfunction : read_word

    assign pins = resolve_pins(pin_level, pin_driven);
    assign flag_mode = config_q[CFG_FLAG_MODE_BIT];
    assign disable_active = flag_mode ? 1'b0 : pins.disable_or_fault_pin;
    assign bridge_enabled = pins.enable_pin_alias & ~disable_active;
    assign channels_on = config_q[CFG_EN_FIRST_BIT] & config_q[CFG_EN_SECOND_BIT];
    assign shutdown = fault_in.over_temp | fault_in.over_current;

    // Release on enable rise or disable fall
    assign reactivate = (pins.enable_pin_alias & ~enable_prev_q & ~disable_active)
                      | (~flag_mode & ~pins.disable_or_fault_pin & disable_prev_q
                         & pins.enable_pin_alias);

    assign outputs_active = (mode_d == MODE_NORMAL);

    assign level_one = config_q[CFG_SERIAL_CTRL_BIT] ? config_q[CFG_SERIAL_ONE_BIT]
                                                     : pins.drive_input_one;
    assign level_two = config_q[CFG_SERIAL_CTRL_BIT] ? config_q[CFG_SERIAL_TWO_BIT]
                                                     : pins.drive_input_two;

    limit_pulse u_pulse_one (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .trigger(fault_in.limit_one & outputs_active),
        .active(pulse_one)
    );

    limit_pulse u_pulse_two (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .trigger(fault_in.limit_two & outputs_active),
        .active(pulse_two)
    );

    // Bridge next state
    always_comb begin
        lockout_d = shutdown | (lockout_q & ~reactivate);
        if (fault_in.logic_supply_bad) begin
            mode_d = MODE_STANDBY;
        end else if (lockout_d | fault_in.supply_under) begin
            mode_d = MODE_FAULT;
        end else if (bridge_enabled & channels_on) begin
            mode_d = MODE_NORMAL;
        end else if (~bridge_enabled & channels_on) begin
            mode_d = MODE_DIAG;
        end else begin
            mode_d = MODE_STANDBY;
        end
        // Flag low on shutdown faults or enable low
        flag_low_d = flag_mode & ~fault_in.logic_supply_bad
                   & (fault_in.supply_under | lockout_d | ~pins.enable_pin_alias);
        one_o_d = 1'b0;
        two_o_d = 1'b0;
        one_oe_d = 1'b0;
        two_oe_d = 1'b0;
        case (mode_d)
            MODE_NORMAL: begin
                one_o_d = level_one | pulse_one;
                two_o_d = level_two | pulse_two;
                one_oe_d = 1'b1;
                two_oe_d = 1'b1;
            end
            MODE_STANDBY, MODE_DIAG, MODE_FAULT: begin
                one_oe_d = 1'b0;
                two_oe_d = 1'b0;
            end
            default: begin
                one_oe_d = 1'b0;
                two_oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= MODE_STANDBY;
            lockout_q <= 1'b0;
            enable_prev_q <= 1'b0;
            disable_prev_q <= 1'b1;
            flag_low_q <= 1'b0;
            one_o_q <= 1'b0;
            one_oe_q <= 1'b0;
            two_o_q <= 1'b0;
            two_oe_q <= 1'b0;
        end else if (ce) begin
            mode_q <= mode_d;
            lockout_q <= lockout_d;
            enable_prev_q <= pins.enable_pin_alias;
            disable_prev_q <= pins.disable_or_fault_pin;
            flag_low_q <= flag_low_d;
            one_o_q <= one_o_d;
            one_oe_q <= one_oe_d;
            two_o_q <= two_o_d;
            two_oe_q <= two_oe_d;
        end
    end

    // Sticky events
    always_comb begin
        events = '0;
        events[EVT_SHUTDOWN_BIT] = shutdown;
        events[EVT_SUPPLY_BIT] = fault_in.supply_under;
        events[EVT_LIMIT_BIT] = pulse_one | pulse_two;
        events[EVT_LOGIC_SUPPLY_BIT] = fault_in.logic_supply_bad;
    end

    assign addr_phase = hsel & htrans[1] & hready;

    // Register file and bus next state
    always_comb begin
        config_d = config_q;
        mask_d = mask_q;
        status_d = status_q;
        addr_d = addr_q;
        wr_d = 1'b0;
        if (wr_q && addr_q == CONFIG_ADDR) begin
            config_d = hwdata[CFG_WIDTH-1:0];
        end
        if (wr_q && addr_q == MASK_ADDR) begin
            mask_d = hwdata[EVT_WIDTH-1:0];
        end
        if (wr_q && addr_q == STATUS_ADDR) begin
            status_d = status_q & ~hwdata[EVT_WIDTH-1:0];
        end
        status_d = status_d | events;
        if (addr_phase) begin
            // Addresses above the low byte map to nothing
            addr_d = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
            wr_d = hwrite;
        end
        hrdata_d = hrdata_q;
        if (addr_phase && !hwrite) begin
            hrdata_d = read_word(addr_d, config_d, status_d, mask_d,
                                 {two_o_q, one_o_q, pins.disable_or_fault_pin,
                                  pins.enable_pin_alias, flag_low_q, lockout_q,
                                  2'(mode_q)});
        end
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            config_q <= CONFIG_RESET;
            status_q <= STATUS_RESET;
            mask_q <= MASK_RESET;
            addr_q <= 8'h00;
            wr_q <= 1'b0;
            hrdata_q <= 32'h00000000;
            hreadyout_q <= 1'b1;
            irq_q <= 1'b0;
        end else if (ce) begin
            config_q <= config_d;
            status_q <= status_d;
            mask_q <= mask_d;
            addr_q <= addr_d;
            wr_q <= wr_d;
            hrdata_q <= hrdata_d;
            hreadyout_q <= 1'b1;
            irq_q <= irq_d;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign irq = irq_q;
    assign disable_or_fault_pin_o = 1'b0;
    assign disable_or_fault_pin_oe = flag_low_q;
    assign bridge_output_one_o = one_o_q;
    assign bridge_output_one_oe = one_oe_q;
    assign bridge_output_two_o = two_o_q;
    assign bridge_output_two_oe = two_oe_q;

endmodule : h_bridge_control_logic

/* testbench/host_pins.sv */
// Host model driving the bridge control pins, with pin pulls applied.
// Assumes the flag pin is released by the host whenever flag mode is used.
`timescale 1ns/10ps
module host_pins
    import hbridge_pkg::*;
(
    input wire logic [3:0] want_level,
    input wire logic [3:0] want_drive,
    input wire logic flag_oe,
    output ctrl_pins_t pin_level,
    output ctrl_pins_t pin_driven
);
    assign pin_level = ctrl_pins_t'(((want_level & want_drive) | (PIN_PULL & ~want_drive))
        & {3'h7, ~flag_oe});
    assign pin_driven = ctrl_pins_t'(want_drive | {3'h0, flag_oe});
endmodule : host_pins

/* testbench/hb_props.sv */
// Concurrent checks on the bridge block's ports.
// Bound into every instance of the top module.
`timescale 1ns/10ps
module hb_props
    import hbridge_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire ctrl_pins_t pin_level,
    input wire fault_in_t fault_in,
    input wire logic disable_or_fault_pin_o,
    input wire logic disable_or_fault_pin_oe,
    input wire logic bridge_output_one_oe,
    input wire logic bridge_output_two_oe,
    input wire logic irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic off;
    assign off = !bridge_output_one_oe && !bridge_output_two_oe;
    a_en_low_hiz: assert property (ce && !pin_level.enable_pin_alias |=> off)
        else $error("outputs driven with enable low");
    a_fault_hiz: assert property (ce && (fault_in.over_temp || fault_in.over_current
        || fault_in.supply_under) |=> off) else $error("outputs driven during fault");
    a_lock_hold: assert property (ce && $fell(fault_in.over_temp) && $stable(pin_level)
        |=> off) else $error("lockout not latched");
    a_logic_bad: assert property (ce && fault_in.logic_supply_bad
        |=> off && !disable_or_fault_pin_oe) else $error("logic supply fault handling");
    a_limit_flag: assert property (ce && $rose(fault_in.limit_one) && fault_in == 6'h02
        && $stable(pin_level) && !disable_or_fault_pin_oe |=> !disable_or_fault_pin_oe)
        else $error("flag raised by current limit");
    a_flag_drain: assert property (!disable_or_fault_pin_o)
        else $error("flag pin driven high");
    a_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus wait or error response");
    a_unmapped_zero: assert property (ce && hsel && htrans[1] && hready && !hwrite
        && haddr > 32'h0C |=> hrdata == 32'h0) else $error("unmapped read not zero");
    cover property (fault_in.over_temp ##3 off);
    cover property ($rose(irq));
    cover property ($rose(fault_in.limit_one));
endmodule : hb_props
bind h_bridge_control_logic hb_props u_props (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hrdata, .hreadyout, .hresp, .pin_level, .fault_in,
    .disable_or_fault_pin_o, .disable_or_fault_pin_oe, .bridge_output_one_oe,
    .bridge_output_two_oe, .irq);

/* testbench/h_bridge_control_logic_tb.sv */
// Self-checking bench: AHB-Lite register tasks plus pin and fault scenarios.
// Assumes one slave on the bus and zero-latency pin pulls in the host model.
`timescale 1ns/10ps
module h_bridge_control_logic_tb
    import hbridge_pkg::*;
;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
    logic [1:0] htrans = 0;
    logic [3:0] lv = 4'hE, dv = 4'hF;
    fault_in_t fault_in = '0;
    ctrl_pins_t pin_level, pin_driven;
    logic hreadyout, hresp, fo, foe, o1, oe1, o2, oe2, irq;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    always #4 hclk = ~hclk;
    assign hready = hreadyout;
    h_bridge_control_logic u_dut (.hclk, .hresetn, .ce(1'h1), .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pin_level, .pin_driven,
        .fault_in, .disable_or_fault_pin_o(fo), .disable_or_fault_pin_oe(foe),
        .bridge_output_one_o(o1), .bridge_output_one_oe(oe1), .bridge_output_two_o(o2),
        .bridge_output_two_oe(oe2), .irq);
    host_pins u_host (.want_level(lv), .want_drive(dv), .flag_oe(foe), .pin_level, .pin_driven);
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task settle;
        repeat (3) @(posedge hclk);
        #1;
    endtask : settle
    task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        rv = hrdata;
        repeat (25) @(posedge hclk);
    endtask : xf
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        xf(1'h0, a, 32'h0);
        chk(nm, rv, exp);
    endtask : rdc
    task cfg(input logic [31:0] d);
        xf(1'h1, CONFIG_ADDR, d);
        settle;
    endtask : cfg
    task go(input logic [3:0] l, input logic [3:0] d);
        @(posedge hclk);
        lv <= l;
        dv <= d;
        settle;
    endtask : go
    task fset(input logic [5:0] f);
        @(posedge hclk);
        fault_in <= f;
        settle;
    endtask : fset
    task out(input logic [3:0] e);
        chk("bridge", {oe1, o1 & oe1, oe2, o2 & oe2}, e);
    endtask : out
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop;
        end
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        rdc("config", CONFIG_ADDR, 32'h3);
        rdc("status", STATUS_ADDR, 32'h0);
        rdc("mask", MASK_ADDR, 32'h0);
        xf(1'h1, 8'h10, 32'hFF);
        rdc("unmapped", 8'h10, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            go({i[1:0], 2'h2}, 4'hF);
            out({1'h1, i[1], 1'h1, i[0]});
        end
        go(4'h2, 4'h7);
        out(4'hE);
        go(4'hE, 4'hD);
        out(4'h0);
        go(4'hF, 4'hF);
        out(4'h0);
        rdc("state", STATE_ADDR, 32'h32);
        go(4'hC, 4'hE);
        out(4'h0);
        $display("test pins done");
        go(4'hE, 4'hF);
        for (int c = 0; c < 4; c++) begin
            cfg(c);
            out(c == 3 ? 4'hF : 4'h0);
        end
        go(4'h6, 4'hF);
        cfg(32'h1B);
        out(4'hE);
        cfg(32'h2B);
        out(4'hB);
        $display("test channels done");
        go(4'hE, 4'hE);
        cfg(32'h7);
        out(4'hF);
        chk("flag", foe, 1'h0);
        xf(1'h1, MASK_ADDR, 32'h1 << EVT_SHUTDOWN_BIT);
        fset(6'h10);
        fset(6'h00);
        out(4'h0);
        chk("flag", foe, 1'h1);
        rdc("state", STATE_ADDR, 32'h1F);
        chk("irq", irq, 1'h1);
        rdc("status", STATUS_ADDR, 32'h1 << EVT_SHUTDOWN_BIT);
        rdc("config", CONFIG_ADDR, 32'h7);
        xf(1'h1, STATUS_ADDR, 32'h1 << EVT_SHUTDOWN_BIT);
        settle;
        chk("irq", irq, 1'h0);
        go(4'hC, 4'hE);
        chk("flag", foe, 1'h1);
        repeat (250) @(posedge hclk);
        go(4'hE, 4'hE);
        out(4'hF);
        chk("flag", foe, 1'h0);
        $display("test lockout done");
        go(4'h2, 4'hE);
        out(4'hA);
        @(posedge hclk);
        fault_in <= 6'h02;
        fset(6'h00);
        out(4'hE);
        chk("flag", foe, 1'h0);
        repeat (LIMIT_ON_CYCLES - 4) @(posedge hclk);
        #1;
        out(4'hE);
        repeat (4) @(posedge hclk);
        #1;
        out(4'hA);
        fset(6'h04);
        out(4'h0);
        chk("flag", foe, 1'h0);
        fset(6'h20);
        out(4'h0);
        chk("flag", foe, 1'h1);
        fset(6'h00);
        rdc("events", STATUS_ADDR, 32'hE);
        $display("test faults done");
        report_and_stop;
    end
endmodule : h_bridge_control_logic_tb
